/* File: design/lrc_pkg.sv */
// Package: register map, field positions, reset values and carrier types of the receive config bank
package lrc_pkg;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 13;
  // Register indices and block numbers; byte address is four times the index
  localparam logic [5:0] IDX_LINE_CFG = 6'h0a;
  localparam logic [5:0] IDX_FMT_CFG = 6'h0b;
  localparam logic [5:0] IDX_GAIN_CFG = 6'h0c;
  localparam logic [5:0] IDX_LOS_CFG = 6'h0d;
  localparam logic [4:0] CH0_BLOCK = 5'h1f;
  localparam logic [4:0] LAST_BLOCK = 5'h0e;
  localparam logic [4:0] GLOBAL_BLOCK = 5'h0f;
  localparam logic [5:0] IDX_GLOBAL_CFG = 6'h00;
  localparam logic [5:0] IDX_INT_STATUS = 6'h01;
  localparam logic [5:0] IDX_INT_CLEAR = 6'h02;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h03;
  localparam logic [5:0] IDX_LOS_LIVE = 6'h04;
  // Reset values
  localparam logic [7:0] RST_LINE_CFG = 8'h47;
  localparam logic [7:0] RST_FMT_CFG = 8'h01;
  localparam logic [7:0] RST_GAIN_CFG = 8'h00;
  localparam logic [7:0] RST_LOS_CFG = 8'h15;
  localparam logic [7:0] RST_GLOBAL_CFG = 8'h00;
  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_LINE_CFG = 8'hff;
  localparam logic [7:0] MASK_FMT_CFG = 8'h1f;
  localparam logic [7:0] MASK_GAIN_CFG = 8'h03;
  localparam logic [7:0] MASK_LOS_CFG = 8'hff;
  localparam logic [7:0] MASK_GLOBAL_CFG = 8'h07;
  // Field positions
  localparam int POS_POWERDOWN_HIZ = 6;
  localparam int POS_POWERDOWN = 5;
  localparam int POS_FULL_INTERNAL = 4;
  localparam int POS_SINGLE_ENDED = 3;
  localparam int POS_TERM = 0;
  localparam int POS_CLK_EDGE = 4;
  localparam int POS_DATA_POL = 3;
  localparam int POS_AMI = 2;
  localparam int POS_SYS_FMT = 0;
  localparam int POS_GAIN = 0;
  localparam int POS_CRITERIA = 7;
  localparam int POS_THRESHOLD = 4;
  localparam int POS_G_E1 = 0;
  localparam int POS_G_PERCH_MATCH = 1;
  localparam int POS_G_MONITOR = 2;
  // Pulse-interval counts for loss declaration, per criteria set
  localparam logic [11:0] LOS_N_STD = 12'd175;
  localparam logic [11:0] LOS_N_ALT = 12'd1544;
  typedef enum logic [1:0] {
    LRC_FMT_NRZ = 2'b01,
    LRC_FMT_RZ = 2'b10,
    LRC_FMT_SLICED = 2'b11
  } lrc_sys_fmt_e;
  // Analog receive controls handed to the line front end
  typedef struct packed {
    logic powered_down;
    logic single_ended;
    logic internal_match;
    logic full_internal;
    logic [1:0] ohms_sel;
    logic [1:0] monitor_gain_sel;
  } lrc_analog_s;
  // System-side receive outputs of one channel
  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } lrc_rx_out_s;
endpackage

/* File: design/lrc_regs.sv */
// Per-channel receive configuration register bank with APB slave, receive formatting and loss detection
//
// Notes on behaviour
// RULE_01 - Power-down bit 5 of line config powers receiver down; clear by default.
// RULE_02 - Bit 4 picks partial or full internal matching, differential per-channel only.
// RULE_03 - Bit 3 zero, the default, selects differential reception on tip and ring.
// RULE_04 - Differential termination codes 000-011 pick 100/110/120/75 ohm; 1xx external.
// RULE_05 - Termination field matters only per-channel; single-ended always external.
// RULE_06 - Format bit 4 chooses rising or falling active edge of output clock.
// RULE_07 - Format bit 3 makes both data rails active high or active low.
// RULE_08 - Format bit 2 chooses B8ZS/HDB3 decoding or plain AMI.
// RULE_09 - System format 01 gives dual-rail NRZ with recovered clock.
// RULE_10 - System format 10 gives dual-rail RZ data with recovered clock.
// RULE_11 - System format 11 gives slicer RZ data directly, no decoding.
// RULE_12 - Every channel register repeats per channel at 0x40 stride, channel zero separate; the global registers sit once in block 0x0f.
// RULE_13 - Monitor gain field selects 0, 20, 26 or 32 dB.
// RULE_14 - Loss config bit 7 picks standard or alternative loss criteria set.
// RULE_15 - Line loss declared after N consecutive intervals below amplitude threshold.
// RULE_16 - Threshold code maps differently in normal and monitor receive modes.
// RULE_17 - Powered-down receiver drives its system outputs low or releases them.
// RULE_18 - Reserved bits read zero and writes to them do nothing.
module lrc_regs
  import lrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lrc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_clk,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_tip,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_ring,
  input wire logic [lrc_pkg::NUM_CH-1:0][11:0] rx_amplitude_mv,
  output lrc_pkg::lrc_rx_out_s [lrc_pkg::NUM_CH-1:0] rx_out,
  output logic [lrc_pkg::NUM_CH-1:0] rx_out_oe,
  output lrc_pkg::lrc_analog_s [lrc_pkg::NUM_CH-1:0] rx_analog,
  output logic [lrc_pkg::NUM_CH-1:0] line_loss_of_signal,
  output logic irq
);
  import lrc_pkg::*;

  // Address decode: block number in index bits 10:6, register in bits 5:0
  function automatic logic [4:0] chan_of(input logic [4:0] blk);
    chan_of = (blk == CH0_BLOCK) ? 5'h00 : blk + 5'h01;
  endfunction

  function automatic logic [11:0] threshold_mv(input logic [2:0] code, input logic monitor);
    logic [11:0] t;
    t = 12'd0;
    if (monitor) begin
      case (code[1:0])
        2'b00: t = 12'd1000;
        2'b01: t = 12'd1400;
        2'b10: t = 12'd1800;
        default: t = 12'd2200;
      endcase
    end else begin
      case (code)
        3'b000: t = 12'd500;
        3'b001: t = 12'd700;
        3'b010: t = 12'd900;
        3'b011: t = 12'd1200;
        3'b100: t = 12'd1400;
        3'b101: t = 12'd1600;
        3'b110: t = 12'd1800;
        default: t = 12'd2000;
      endcase
    end
    threshold_mv = t;
  endfunction

  logic [7:0] line_cfg_reg [NUM_CH];
  logic [7:0] fmt_cfg_reg [NUM_CH];
  logic [7:0] gain_cfg_reg [NUM_CH];
  logic [7:0] los_cfg_reg [NUM_CH];
  logic [7:0] global_cfg_reg;
  logic [NUM_CH-1:0] int_status_reg;
  logic [NUM_CH-1:0] int_enable_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  wire logic [10:0] idx = paddr[12:2];
  wire logic [4:0] blk = idx[10:6];
  wire logic [5:0] reg_sel = idx[5:0];
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic chan_blk = (blk <= LAST_BLOCK) || (blk == CH0_BLOCK); // RULE_12
  wire logic [4:0] chan_full = chan_of(blk); // RULE_12
  wire logic [3:0] chan = chan_full[3:0]; // RULE_12
  wire logic hit_line = chan_blk && (reg_sel == IDX_LINE_CFG);
  wire logic hit_fmt = chan_blk && (reg_sel == IDX_FMT_CFG);
  wire logic hit_gain = chan_blk && (reg_sel == IDX_GAIN_CFG);
  wire logic hit_los = chan_blk && (reg_sel == IDX_LOS_CFG);
  wire logic glob_blk = (blk == GLOBAL_BLOCK);
  wire logic hit_gcfg = glob_blk && (reg_sel == IDX_GLOBAL_CFG);
  wire logic hit_stat = glob_blk && (reg_sel == IDX_INT_STATUS);
  wire logic hit_clr = glob_blk && (reg_sel == IDX_INT_CLEAR);
  wire logic hit_en = glob_blk && (reg_sel == IDX_INT_ENABLE);
  wire logic hit_live = glob_blk && (reg_sel == IDX_LOS_LIVE);
  wire logic mapped = aligned && (hit_line || hit_fmt || hit_gain || hit_los || hit_gcfg || hit_stat || hit_clr ||
                                  hit_en || hit_live);
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic wr_ok = access && pwrite && mapped && pstrb[0];
  wire logic [15:0] wr16 = {pstrb[1] ? pwdata[15:8] : 8'h00, pwdata[7:0]};
  wire logic clr_hit = wr_ok && hit_clr;

  // Read data is captured in the setup cycle; every access completes in one access cycle
  wire logic [7:0] chan_rd = hit_line ? line_cfg_reg[chan] :
                             hit_fmt ? fmt_cfg_reg[chan] :
                             hit_gain ? gain_cfg_reg[chan] :
                             hit_los ? los_cfg_reg[chan] : 8'h00;
  wire logic [31:0] rd_word = chan_blk ? {24'h000000, chan_rd} :
                              hit_gcfg ? {24'h000000, global_cfg_reg} :
                              hit_stat ? {16'h0000, int_status_reg} :
                              hit_en ? {16'h0000, int_enable_reg} :
                              hit_live ? {16'h0000, line_loss_of_signal} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= (!pwrite && mapped) ? rd_word : 32'h00000000;
      pslverr_reg <= !mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access && pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_cfg_reg <= RST_GLOBAL_CFG;
      int_enable_reg <= 16'h0000;
    end else if (wr_ok && hit_gcfg) begin
      global_cfg_reg <= pwdata[7:0] & MASK_GLOBAL_CFG; // RULE_18
    end else if (wr_ok && hit_en) begin
      int_enable_reg <= wr16;
    end
  end

  wire logic e1_mode = global_cfg_reg[POS_G_E1];
  wire logic perch_match = global_cfg_reg[POS_G_PERCH_MATCH];
  wire logic monitor_mode = global_cfg_reg[POS_G_MONITOR];
  logic [NUM_CH-1:0] loss_rise;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      logic [1:0] clk_sync_reg;
      logic [1:0] tip_sync_reg;
      logic [1:0] ring_sync_reg;
      logic [11:0] amp_sync0_reg;
      logic [11:0] amp_sync1_reg;
      logic clk_prev_reg;
      logic [7:0] mark_reg;
      logic [7:0] pol_reg;
      logic [7:0] viol_reg;
      logic last_pol_reg;
      logic [11:0] below_cnt_reg;
      logic loss_reg;
      logic pos_reg;
      logic neg_reg;
      logic slice_pos_reg;
      logic slice_neg_reg;
      wire logic wsel = wr_ok && (chan == 4'(g));
      wire logic [7:0] lcfg = line_cfg_reg[g];
      wire logic [7:0] fcfg = fmt_cfg_reg[g];
      wire logic [7:0] lscfg = los_cfg_reg[g];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          line_cfg_reg[g] <= RST_LINE_CFG;
          fmt_cfg_reg[g] <= RST_FMT_CFG;
          gain_cfg_reg[g] <= RST_GAIN_CFG;
          los_cfg_reg[g] <= RST_LOS_CFG;
        end else if (wsel) begin
          if (hit_line) line_cfg_reg[g] <= pwdata[7:0] & MASK_LINE_CFG;
          if (hit_fmt) fmt_cfg_reg[g] <= pwdata[7:0] & MASK_FMT_CFG; // RULE_18
          if (hit_gain) gain_cfg_reg[g] <= pwdata[7:0] & MASK_GAIN_CFG; // RULE_18
          if (hit_los) los_cfg_reg[g] <= pwdata[7:0] & MASK_LOS_CFG;
        end
      end

      // Line-side inputs come from outside this clock and pass two flops first
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clk_sync_reg <= 2'b00;
          tip_sync_reg <= 2'b00;
          ring_sync_reg <= 2'b00;
          amp_sync0_reg <= 12'h000;
          amp_sync1_reg <= 12'h000;
          clk_prev_reg <= 1'b0;
        end else begin
          clk_sync_reg <= {clk_sync_reg[0], rx_line_clk[g]};
          tip_sync_reg <= {tip_sync_reg[0], rx_line_tip[g]};
          ring_sync_reg <= {ring_sync_reg[0], rx_line_ring[g]};
          amp_sync0_reg <= rx_amplitude_mv[g];
          amp_sync1_reg <= amp_sync0_reg;
          clk_prev_reg <= clk_sync_reg[1];
        end
      end

      wire logic powered_down = lcfg[POS_POWERDOWN]; // RULE_01
      wire logic single_ended = lcfg[POS_SINGLE_ENDED]; // RULE_03
      // Single-ended reception uses only the tip input
      wire logic in_pos = tip_sync_reg[1] && (single_ended || !ring_sync_reg[1]); // RULE_03
      wire logic in_neg = ring_sync_reg[1] && !single_ended && !tip_sync_reg[1]; // RULE_03
      wire logic line_edge = clk_sync_reg[1] && !clk_prev_reg && !powered_down; // RULE_01
      wire logic new_mark = in_pos || in_neg;
      wire logic is_viol = new_mark && (in_pos == last_pol_reg) && (pol_reg != 8'h00 || mark_reg != 8'h00);
      wire logic ami = fcfg[POS_AMI]; // RULE_08
      // HDB3 violation removes itself and the three bits before it
      wire logic hdb3_sub = !ami && e1_mode && is_viol; // RULE_08
      // B8ZS 000VB0VB completes when the last B arrives
      wire logic b8zs_sub = !ami && !e1_mode && new_mark && viol_reg[0] && viol_reg[3] && mark_reg[0] &&
                            mark_reg[2] && mark_reg[3]; // RULE_08
      wire logic [11:0] need_n = lscfg[POS_CRITERIA] ? LOS_N_ALT : LOS_N_STD; // RULE_14
      wire logic [11:0] thr = threshold_mv(lscfg[POS_THRESHOLD +: 3], monitor_mode); // RULE_16
      wire logic below = amp_sync1_reg < thr; // RULE_15

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mark_reg <= 8'h00;
          pol_reg <= 8'h00;
          viol_reg <= 8'h00;
          last_pol_reg <= 1'b0;
          below_cnt_reg <= 12'h000;
          loss_reg <= 1'b0;
          pos_reg <= 1'b0;
          neg_reg <= 1'b0;
          slice_pos_reg <= 1'b0;
          slice_neg_reg <= 1'b0;
        end else if (line_edge) begin
          mark_reg <= hdb3_sub ? {mark_reg[6:3], 4'h0} :
                      b8zs_sub ? {mark_reg[6:3], 4'h0} : {mark_reg[6:0], new_mark}; // RULE_08
          pol_reg <= {pol_reg[6:0], in_pos};
          viol_reg <= {viol_reg[6:0], is_viol && !hdb3_sub};
          if (new_mark) last_pol_reg <= in_pos;
          pos_reg <= mark_reg[7] && pol_reg[7];
          neg_reg <= mark_reg[7] && !pol_reg[7];
          slice_pos_reg <= in_pos; // RULE_11
          slice_neg_reg <= in_neg; // RULE_11
          if (!below) begin
            below_cnt_reg <= 12'h000;
            loss_reg <= 1'b0;
          end else if (below_cnt_reg >= need_n - 12'd1) begin
            loss_reg <= 1'b1; // RULE_15
          end else begin
            below_cnt_reg <= below_cnt_reg + 12'd1; // RULE_15
          end
        end
      end

      logic loss_prev_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          loss_prev_reg <= 1'b0;
        end else begin
          loss_prev_reg <= loss_reg;
        end
      end
      assign loss_rise[g] = loss_reg && !loss_prev_reg;
      assign line_loss_of_signal[g] = loss_reg;

      // System-side output formatting
      wire logic [1:0] sys_fmt = fcfg[POS_SYS_FMT +: 2];
      wire logic clk_lvl = clk_sync_reg[1];
      wire logic fmt_pos = (sys_fmt == LRC_FMT_SLICED) ? slice_pos_reg && clk_lvl : // RULE_11
                           (sys_fmt == LRC_FMT_RZ) ? pos_reg && clk_lvl : pos_reg; // RULE_09 RULE_10
      wire logic fmt_neg = (sys_fmt == LRC_FMT_SLICED) ? slice_neg_reg && clk_lvl : // RULE_11
                           (sys_fmt == LRC_FMT_RZ) ? neg_reg && clk_lvl : neg_reg; // RULE_09 RULE_10
      wire logic inv = fcfg[POS_DATA_POL]; // RULE_07
      wire logic edge_inv = fcfg[POS_CLK_EDGE]; // RULE_06
      logic [2:0] out_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_reg <= 3'b000;
        end else if (powered_down) begin
          out_reg <= 3'b000; // RULE_17
        end else begin
          out_reg <= {clk_lvl ^ edge_inv, fmt_pos ^ inv, fmt_neg ^ inv}; // RULE_06 RULE_07
        end
      end
      assign rx_out[g] = out_reg;
      assign rx_out_oe[g] = !(powered_down && lcfg[POS_POWERDOWN_HIZ]); // RULE_17

      // Termination only acts per channel and in differential mode
      wire logic term_ok = perch_match && !single_ended; // RULE_05
      assign rx_analog[g].powered_down = powered_down; // RULE_01
      assign rx_analog[g].single_ended = single_ended; // RULE_03
      assign rx_analog[g].internal_match = term_ok && !lcfg[POS_TERM + 2]; // RULE_04 RULE_05
      assign rx_analog[g].full_internal = term_ok && lcfg[POS_FULL_INTERNAL]; // RULE_02
      assign rx_analog[g].ohms_sel = term_ok ? lcfg[POS_TERM +: 2] : 2'b00; // RULE_04
      assign rx_analog[g].monitor_gain_sel = gain_cfg_reg[g][POS_GAIN +: 2]; // RULE_13
    end
  endgenerate

  // Sticky loss events: set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= 16'h0000;
    end else begin
      int_status_reg <= (int_status_reg & ~(clr_hit ? wr16 : 16'h0000)) | loss_rise;
    end
  end

  assign irq = |(int_status_reg & int_enable_reg);
endmodule

/* File: sim/lrc_regs_checker.sv */
// Port-level concurrent checks for the receive configuration bank
module lrc_regs_checker
  import lrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lrc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_clk,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_tip,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_line_ring,
  input wire logic [lrc_pkg::NUM_CH-1:0][11:0] rx_amplitude_mv,
  input wire lrc_pkg::lrc_rx_out_s [lrc_pkg::NUM_CH-1:0] rx_out,
  input wire logic [lrc_pkg::NUM_CH-1:0] rx_out_oe,
  input wire lrc_pkg::lrc_analog_s [lrc_pkg::NUM_CH-1:0] rx_analog,
  input wire logic [lrc_pkg::NUM_CH-1:0] line_loss_of_signal,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reserved_fmt_a: assert property (psel && penable && !pwrite && !pslverr && paddr[7:2] == IDX_FMT_CFG
    |-> prdata[31:5] == 27'h0) else $error("Reserved format bits read nonzero");
  reserved_gain_a: assert property (psel && penable && !pwrite && !pslverr && paddr[7:2] == IDX_GAIN_CFG
    |-> prdata[31:2] == 30'h0) else $error("Reserved gain bits read nonzero");
  misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("Misaligned access not refused");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("Error response outside access phase");
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    single_ext_a: assert property (rx_analog[c].single_ended |-> !rx_analog[c].internal_match)
      else $error("Single-ended receiver with internal matching");
    oe_when_on_a: assert property (!rx_analog[c].powered_down && !$past(rx_analog[c].powered_down)
      |-> rx_out_oe[c]) else $error("Outputs released while receiver on");
    pd_low_drive_a: assert property (rx_analog[c].powered_down && $past(rx_analog[c].powered_down)
      && rx_out_oe[c] && $past(rx_out_oe[c]) |-> rx_out[c] == 3'b000)
      else $error("Powered-down outputs not low");
    pd_loss_hold_a: assert property (rx_analog[c].powered_down && $past(rx_analog[c].powered_down, 4)
      |-> $stable(line_loss_of_signal[c])) else $error("Loss moved while powered down");
    gain_by_write_a: assert property ($changed(rx_analog[c].monitor_gain_sel)
      |-> $past(psel) && $past(penable) && $past(pwrite)) else $error("Gain changed without a write");
    full_by_write_a: assert property ($changed(rx_analog[c].full_internal)
      |-> $past(psel) && $past(penable) && $past(pwrite)) else $error("Match mode changed without a write");
  end
  irq_seen_c: cover property (irq);
  hiz_seen_c: cover property (!rx_out_oe[1]);
  loss_seen_c: cover property ($rose(line_loss_of_signal[1]));
  err_seen_c: cover property (pslverr);
endmodule

bind lrc_regs lrc_regs_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .rx_line_clk, .rx_line_tip, .rx_line_ring, .rx_amplitude_mv, .rx_out,
  .rx_out_oe, .rx_analog, .line_loss_of_signal, .irq);

/* File: sim/lrc_framer_model.sv */
// Line-side source feeding every channel with marks, amplitude and a recovered clock
module lrc_framer_model
  import lrc_pkg::*;
(
  input wire logic run,
  input wire logic tip_val,
  input wire logic ring_val,
  input wire logic [11:0] amp_val,
  output logic [lrc_pkg::NUM_CH-1:0] rx_line_clk,
  output logic [lrc_pkg::NUM_CH-1:0] rx_line_tip,
  output logic [lrc_pkg::NUM_CH-1:0] rx_line_ring,
  output logic [lrc_pkg::NUM_CH-1:0][11:0] rx_amplitude_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk = 1'b0;
  assign rx_line_clk = {NUM_CH{lclk}};
  initial begin
    forever begin
      // Marks and amplitude move only while the clock is low
      rx_line_tip = {NUM_CH{tip_val}};
      rx_line_ring = {NUM_CH{ring_val}};
      rx_amplitude_mv = {NUM_CH{amp_val}};
      if (run) begin
        #400 lclk = 1'b1;
        #400 lclk = 1'b0;
      end else begin
        #100;
      end
    end
  end
endmodule

/* File: sim/lrc_regs_tb_top.sv */
// Self-checking bench for the receive configuration bank
module lrc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lrc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, er;
  logic run = 1'b0;
  logic tip_val = 1'b0;
  logic ring_val = 1'b0;
  logic [11:0] amp_val = 12'd2000;
  logic [NUM_CH-1:0] lclk, ltip, lring, oe, loss;
  logic [NUM_CH-1:0][11:0] lamp;
  lrc_rx_out_s [NUM_CH-1:0] rx_out;
  lrc_analog_s [NUM_CH-1:0] ana;
  logic [7:0] mdl [NUM_CH][4];
  logic [7:0] msk [4] = '{MASK_LINE_CFG, MASK_FMT_CFG, MASK_GAIN_CFG, MASK_LOS_CFG};
  logic [7:0] rst [4] = '{RST_LINE_CFG, RST_FMT_CFG, RST_GAIN_CFG, RST_LOS_CFG};
  logic [7:0] gmdl = 8'h00;
  logic [31:0] rd;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 57659;
  lrc_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .rx_line_clk(lclk), .rx_line_tip(ltip), .rx_line_ring(lring), .rx_amplitude_mv(lamp), .rx_out,
    .rx_out_oe(oe), .rx_analog(ana), .line_loss_of_signal(loss), .irq);
  lrc_framer_model PARTNER (.run, .tip_val, .ring_val, .amp_val, .rx_line_clk(lclk), .rx_line_tip(ltip),
    .rx_line_ring(lring), .rx_amplitude_mv(lamp));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [ADDR_W-1:0] ra(input int ch, input int k);
    logic [4:0] b;
    b = (ch == 0) ? CH0_BLOCK : 5'(ch - 1);
    return {b, 6'(IDX_LINE_CFG + k), 2'b00};
  endfunction
  function automatic logic [ADDR_W-1:0] ga(input logic [5:0] idx);
    return {GLOBAL_BLOCK, idx, 2'b00};
  endfunction
  task automatic wr(input int ch, input int k, input logic [7:0] d);
    apb(1'b1, ra(ch, k), {24'h0, d});
    mdl[ch][k] = d & msk[k];
  endtask
  task automatic rdc(input int ch, input int k);
    apb(1'b0, ra(ch, k), 32'h0);
    chk("reg", {24'h0, mdl[ch][k]}, rd);
  endtask
  task automatic gw(input logic [7:0] d);
    apb(1'b1, ga(IDX_GLOBAL_CFG), {24'h0, d});
    gmdl = d & MASK_GLOBAL_CFG;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  initial begin
    #(40000 * 100);
    bad_count++;
    give_verdict();
  end
  initial begin
    int c;
    int k;
    int m;
    for (int i = 0; i < NUM_CH * 4; i++) mdl[i / 4][i % 4] = rst[i % 4];
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_CH * 4; i++) rdc(i / 4, i % 4);
    for (int i = 0; i < 40; i++) begin
      c = $unsigned($random(seed)) % NUM_CH;
      k = $unsigned($random(seed)) % 4;
      wr(c, k, 8'($random(seed)));
      rdc($unsigned($random(seed)) % NUM_CH, $unsigned($random(seed)) % 4);
    end
    apb(1'b0, {5'h10, IDX_LINE_CFG, 2'b00}, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, ra(2, 2) | 13'h1, 32'h3);
    chk("misalign_err", 32'h1, {31'h0, er});
    rdc(2, 2);
    for (int n = 0; n < 32; n++) begin
      gw({6'h0, n[4], 1'b0});
      wr(1, 0, {3'b010, n[0], n[3], n[2:0]});
      settle(1);
      chk("single", n[3], ana[1].single_ended);
      chk("internal", n[4] & !n[3] & !n[2], ana[1].internal_match);
      chk("full", n[4] & !n[3] & n[0], ana[1].full_internal);
      if (n[4] & !n[3] & !n[2]) chk("ohms", n[1:0], ana[1].ohms_sel);
    end
    apb(1'b0, ga(IDX_GLOBAL_CFG), 32'h0);
    chk("global", {24'h0, gmdl}, rd);
    for (int g = 0; g < 4; g++) begin
      wr(1, 2, 8'(g));
      settle(1);
      chk("gain", g, ana[1].monitor_gain_sel);
    end
    for (int h = 0; h < 2; h++) begin
      wr(1, 0, {1'b0, h[0], 6'h20});
      settle(3);
      chk("pd", 32'h1, ana[1].powered_down);
      chk("oe", !h[0], oe[1]);
      if (!h[0]) chk("out_low", 32'h0, rx_out[1]);
    end
    wr(1, 0, 8'h40);
    @(posedge pclk);
    run <= 1'b1;
    tip_val <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      wr(1, 1, {3'b000, i[0], i[1], 1'b1, 2'(i / 4 + 1)});
      repeat (10) @(posedge lclk[1]);
      settle(5);
      chk("clk_hi", !i[0], rx_out[1].clk);
      chk("pos_hi", !i[1], rx_out[1].pos);
      chk("neg_hi", i[1], rx_out[1].neg);
      settle(4);
      chk("clk_lo", i[0], rx_out[1].clk);
      chk("pos_lo", (i / 4 == 0) ^ i[1], rx_out[1].pos);
    end
    wr(1, 1, 8'h01);
    apb(1'b1, ga(IDX_INT_ENABLE), 32'h2);
    for (int p = 0; p < 2; p++) begin
      gw(p ? 8'h02 : 8'h06);
      wr(1, 3, p ? 8'h95 : 8'h15);
      @(posedge pclk);
      amp_val <= p ? 12'd600 : 12'd1000;
      m = p ? int'(LOS_N_ALT) : int'(LOS_N_STD);
      repeat (m - 3) @(posedge lclk[1]);
      settle(6);
      chk("loss_early", 32'h0, loss[1]);
      repeat (6) @(posedge lclk[1]);
      settle(6);
      chk("loss_set", 32'h1, loss[1]);
      chk("irq_set", 32'h1, irq);
      apb(1'b1, ga(IDX_INT_ENABLE), 32'h0);
      settle(2);
      chk("irq_masked", 32'h0, irq);
      apb(1'b1, ga(IDX_INT_ENABLE), 32'h2);
      settle(2);
      chk("irq_on", 32'h1, irq);
      apb(1'b1, ga(IDX_INT_CLEAR), 32'h2);
      settle(2);
      chk("irq_clr", 32'h0, irq);
      apb(1'b0, ga(IDX_INT_STATUS), 32'h0);
      chk("status", 32'h0, rd & 32'h2);
      @(posedge pclk);
      amp_val <= 12'd2000;
      repeat (3) @(posedge lclk[1]);
      settle(6);
      chk("loss_clr", 32'h0, loss[1]);
    end
    give_verdict();
  end
endmodule
